// ===== serial_pkg.sv
// shared constants, types and helpers for the serial line controller
package serial_pkg;

  // register byte addresses, one aligned word each
  localparam logic [11:0] ADDR_DATA = 12'h000; // read: receiver buffer, write: holding
  localparam logic [11:0] ADDR_IEN  = 12'h004;
  localparam logic [11:0] ADDR_IID  = 12'h008;
  localparam logic [11:0] ADDR_LCTL = 12'h00C;
  localparam logic [11:0] ADDR_MCTL = 12'h010;
  localparam logic [11:0] ADDR_LSTA = 12'h014;
  localparam logic [11:0] ADDR_MSTA = 12'h018;
  localparam logic [11:0] ADDR_SCR  = 12'h01C;
  localparam logic [11:0] ADDR_DIV  = 12'h020;

  // reset values
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [15:0] RST_DIV  = 16'h0000; // zero divisor holds the generator still

  // interrupt identity codes, bit 0 low means one is pending
  localparam logic [7:0] IID_NONE  = 8'h01;
  localparam logic [7:0] IID_LINE  = 8'h06;
  localparam logic [7:0] IID_RXRDY = 8'h04;
  localparam logic [7:0] IID_THRE  = 8'h02;
  localparam logic [7:0] IID_MODEM = 8'h00;

  // oversampling: sixteen ticks per bit, start bit checked at its middle
  localparam logic [3:0] TICK_LAST = 4'hF;
  localparam logic [3:0] TICK_MID  = 4'h7;

  // line control layout
  typedef struct packed {
    logic       rsvd;
    logic       break_ctl;
    logic       stick;
    logic       even;
    logic       par_en;
    logic       two_stop;
    logic [1:0] wlen;      // 0: five bits .. 3: eight bits
  } lctl_s;

  // modem control layout
  typedef struct packed {
    logic [2:0] rsvd;
    logic       loop;
    logic       out2;
    logic       out1;
    logic       rts;
    logic       dtr;
  } mctl_s;

  // mask of valid data bits for a word length code
  function automatic logic [7:0] data_mask(input logic [1:0] wlen);
    data_mask = 8'hFF >> (2'd3 - wlen);
  endfunction

  // parity bit to send or expect for the given framing
  function automatic logic par_bit(input logic [7:0] data, input lctl_s lc);
    logic x;
    x = ^(data & data_mask(lc.wlen));
    if (lc.stick) begin
      par_bit = ~lc.even;
    end else begin
      par_bit = lc.even ? x : ~x;
    end
  endfunction

endpackage

// ===== baud_divider.sv
// transmit rate generator producing a sixteen-times tick
`timescale 1ns/1ps
module baud_divider (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [15:0] divisor,
  output logic             tick,
  output logic             baud_n
);

  logic [15:0] cnt_q;

  // count to divisor minus one; a zero divisor stops the tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q  <= 16'h0000;
      baud_n <= 1'b1;
    end else if (divisor == 16'h0000) begin
      cnt_q  <= 16'h0000;
      baud_n <= 1'b1;
    end else if (cnt_q >= divisor - 16'h0001) begin
      cnt_q  <= 16'h0000;
      baud_n <= 1'b0;
    end else begin
      cnt_q  <= cnt_q + 16'h0001;
      baud_n <= 1'b1;
    end
  end

  assign tick = ~baud_n;

endmodule

// ===== rx_glitch_filter.sv
// receive line filter that drops short pulses
`timescale 1ns/1ps
module rx_glitch_filter (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic sample_en,
  input  wire logic line_in,
  output logic      line_out
);

  logic [1:0] hist_q;

  // a level must be seen on three consecutive samples, two full periods
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hist_q   <= 2'b11;
      line_out <= 1'b1;
    end else if (sample_en) begin
      hist_q <= {hist_q[0], line_in};
      if (hist_q[1] == line_in && hist_q[0] == line_in) begin
        line_out <= line_in;
      end
    end
  end

endmodule

// ===== serial_line_ctrl.sv
// asynchronous serial controller with modem control behind an apb slave
//
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/1ps
module serial_line_ctrl (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        master_reset,
  input  wire logic        rclk,
  input  wire logic        serial_rx_line,
  output logic             serial_tx_line,
  output logic             tx_bit_clock_out_n,
  output logic             request_to_send_out_n,
  output logic             terminal_ready_out_n,
  output logic             user_output_one_n,
  output logic             user_output_two_n,
  input  wire logic        carrier_detect_in_n,
  input  wire logic        ring_indicator_in_n,
  input  wire logic        set_ready_in_n,
  input  wire logic        clear_to_send_in_n,
  output logic             irq
);

  typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_e;
  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_e;

  // ----------------------------------------------------------------
  // register bus decode
  // ----------------------------------------------------------------
  serial_pkg::lctl_s lctl_q;
  serial_pkg::mctl_s mctl_q;
  logic [7:0]        ien_q;
  logic [7:0]        scr_q;
  logic [15:0]       div_q;
  logic [7:0]        thr_q;
  logic              thr_full_q;
  logic [7:0]        rbr_q;
  logic              dr_q, oe_q, pe_q, fe_q, bi_q;
  logic              thre_int_q;
  logic [3:0]        mdelta_q;
  logic [3:0]        mprev_q;
  logic [3:0]        mlevel;
  logic [7:0]        iid;
  logic [31:0]       rd_val;
  logic              mapped;
  logic              acc, wr, rd;
  logic [9:0]        widx;

  assign widx   = paddr[11:2];
  assign mapped = (widx <= serial_pkg::ADDR_DIV[11:2]);
  assign acc    = psel & penable & mapped;
  assign wr     = acc & pwrite;
  assign rd     = acc & ~pwrite;
  assign pready = 1'b1; // every access completes without wait states

  // unmapped words answer with an error in the access phase
  always_comb begin
    pslverr = psel & penable & ~mapped;
  end

  function automatic logic hit(input logic [9:0] idx, input logic [11:0] addr);
    hit = (idx == addr[11:2]);
  endfunction

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  // host-written settings; master reset returns all but scratch to defaults
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lctl_q <= serial_pkg::RST_BYTE;
      mctl_q <= serial_pkg::RST_BYTE;
      ien_q  <= serial_pkg::RST_BYTE;
      scr_q  <= serial_pkg::RST_BYTE;
      div_q  <= serial_pkg::RST_DIV;
    end else if (master_reset) begin
      lctl_q <= serial_pkg::RST_BYTE;
      mctl_q <= serial_pkg::RST_BYTE;
      ien_q  <= serial_pkg::RST_BYTE;
      div_q  <= serial_pkg::RST_DIV;
    end else if (wr) begin
      if (hit(widx, serial_pkg::ADDR_LCTL)) lctl_q <= {1'b0, pwdata[6:0]};
      if (hit(widx, serial_pkg::ADDR_MCTL)) mctl_q <= {3'b000, pwdata[4:0]};
      if (hit(widx, serial_pkg::ADDR_IEN))  ien_q  <= {4'h0, pwdata[3:0]};
      if (hit(widx, serial_pkg::ADDR_SCR))  scr_q  <= pwdata[7:0];
      if (hit(widx, serial_pkg::ADDR_DIV))  div_q  <= pwdata[15:0];
    end
  end

  // ----------------------------------------------------------------
  // transmit rate and shifter
  // ----------------------------------------------------------------
  logic      tx_tick;
  tx_state_e tx_st_q;
  logic [3:0] tx_cnt_q;
  logic [2:0] tx_bit_q;
  logic [7:0] tx_sh_q;
  logic       tx_raw_q;
  logic       tx_par_q;
  logic       tx_stop2_q;
  logic       thr_load;

  baud_divider u_baud (
    .pclk    (pclk),
    .presetn (presetn),
    .divisor (div_q),
    .tick    (tx_tick),
    .baud_n  (tx_bit_clock_out_n)
  );

  assign thr_load = tx_tick & (tx_st_q == TX_IDLE) & thr_full_q;

  // holding register; a write in the load cycle keeps it full with new data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      thr_q      <= serial_pkg::RST_BYTE;
      thr_full_q <= 1'b0;
    end else if (master_reset) begin
      thr_full_q <= 1'b0;
    end else if (wr && hit(widx, serial_pkg::ADDR_DATA)) begin
      thr_q      <= pwdata[7:0];
      thr_full_q <= 1'b1;
    end else if (thr_load) begin
      thr_full_q <= 1'b0;
    end
  end

  // frame sequencer, one bit per sixteen ticks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st_q    <= TX_IDLE;
      tx_cnt_q   <= 4'h0;
      tx_bit_q   <= 3'h0;
      tx_sh_q    <= 8'h00;
      tx_raw_q   <= 1'b1;
      tx_par_q   <= 1'b0;
      tx_stop2_q <= 1'b0;
    end else if (master_reset) begin
      tx_st_q  <= TX_IDLE;
      tx_raw_q <= 1'b1;
    end else if (tx_tick) begin
      tx_cnt_q <= (tx_st_q == TX_IDLE) ? 4'h0 : tx_cnt_q + 4'h1;
      unique case (tx_st_q)
        TX_IDLE: begin
          if (thr_full_q) begin
            tx_sh_q  <= thr_q;
            tx_par_q <= serial_pkg::par_bit(thr_q, lctl_q);
            tx_raw_q <= 1'b0;
            tx_st_q  <= TX_START;
          end
        end
        TX_START: begin
          if (tx_cnt_q == serial_pkg::TICK_LAST) begin
            tx_raw_q <= tx_sh_q[0];
            tx_sh_q  <= tx_sh_q >> 1;
            tx_bit_q <= 3'h0;
            tx_st_q  <= TX_DATA;
          end
        end
        TX_DATA: begin
          if (tx_cnt_q == serial_pkg::TICK_LAST) begin
            if (tx_bit_q == {1'b1, lctl_q.wlen}) begin
              tx_raw_q   <= lctl_q.par_en ? tx_par_q : 1'b1;
              tx_st_q    <= lctl_q.par_en ? TX_PAR : TX_STOP;
              tx_stop2_q <= lctl_q.two_stop;
            end else begin
              tx_raw_q <= tx_sh_q[0];
              tx_sh_q  <= tx_sh_q >> 1;
              tx_bit_q <= tx_bit_q + 3'h1;
            end
          end
        end
        TX_PAR: begin
          if (tx_cnt_q == serial_pkg::TICK_LAST) begin
            tx_raw_q <= 1'b1;
            tx_st_q  <= TX_STOP;
          end
        end
        TX_STOP: begin
          if (tx_cnt_q == serial_pkg::TICK_LAST) begin
            if (tx_stop2_q) begin
              tx_stop2_q <= 1'b0;
            end else begin
              tx_st_q <= TX_IDLE;
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // line and modem pins
  // ----------------------------------------------------------------
  // loop-back parks the line at mark and the modem outputs inactive
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_tx_line        <= 1'b1;
      request_to_send_out_n <= 1'b1;
      terminal_ready_out_n  <= 1'b1;
      user_output_one_n     <= 1'b1;
      user_output_two_n     <= 1'b1;
    end else begin
      serial_tx_line        <= mctl_q.loop | (tx_raw_q & ~lctl_q.break_ctl);
      request_to_send_out_n <= ~mctl_q.rts | mctl_q.loop;
      terminal_ready_out_n  <= ~mctl_q.dtr | mctl_q.loop;
      user_output_one_n     <= ~mctl_q.out1 | mctl_q.loop;
      user_output_two_n     <= ~mctl_q.out2 | mctl_q.loop;
    end
  end

  // ----------------------------------------------------------------
  // receiver
  // ----------------------------------------------------------------
  logic       rclk_q;
  logic       rx_tick;
  logic       rx_filt;
  rx_state_e  rx_st_q;
  logic [3:0] rx_cnt_q;
  logic [2:0] rx_bit_q;
  logic [7:0] rx_sh_q;
  logic       rx_parbit_q;
  logic       rx_done_q;
  logic       rx_stop_q;
  logic [7:0] rx_data;
  logic       rx_pe;

  // sample enable from the rising edge of the supplied sixteen-times clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rclk_q <= 1'b0;
    end else begin
      rclk_q <= rclk;
    end
  end
  assign rx_tick = rclk & ~rclk_q;

  rx_glitch_filter u_filt (
    .pclk      (pclk),
    .presetn   (presetn),
    .sample_en (rx_tick),
    .line_in   (mctl_q.loop ? tx_raw_q : serial_rx_line),
    .line_out  (rx_filt)
  );

  // start is confirmed mid bit, so later samples fall at bit centres
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st_q     <= RX_IDLE;
      rx_cnt_q    <= 4'h0;
      rx_bit_q    <= 3'h0;
      rx_sh_q     <= 8'h00;
      rx_parbit_q <= 1'b0;
      rx_done_q   <= 1'b0;
      rx_stop_q   <= 1'b1;
    end else if (master_reset) begin
      rx_st_q   <= RX_IDLE;
      rx_done_q <= 1'b0;
    end else begin
      rx_done_q <= 1'b0;
      if (rx_tick) begin
        rx_cnt_q <= rx_cnt_q + 4'h1;
        unique case (rx_st_q)
          RX_IDLE: begin
            rx_cnt_q <= 4'h0;
            if (!rx_filt) rx_st_q <= RX_START;
          end
          RX_START: begin
            if (rx_cnt_q == serial_pkg::TICK_MID) begin
              rx_cnt_q <= 4'h0;
              rx_bit_q <= 3'h0;
              rx_sh_q  <= 8'h00;
              rx_st_q  <= rx_filt ? RX_IDLE : RX_DATA;
            end
          end
          RX_DATA: begin
            if (rx_cnt_q == serial_pkg::TICK_LAST) begin
              rx_sh_q[rx_bit_q] <= rx_filt;
              rx_bit_q          <= rx_bit_q + 3'h1;
              if (rx_bit_q == {1'b1, lctl_q.wlen}) begin
                rx_st_q <= lctl_q.par_en ? RX_PAR : RX_STOP;
              end
            end
          end
          RX_PAR: begin
            if (rx_cnt_q == serial_pkg::TICK_LAST) begin
              rx_parbit_q <= rx_filt;
              rx_st_q     <= RX_STOP;
            end
          end
          RX_STOP: begin
            if (rx_cnt_q == serial_pkg::TICK_LAST) begin
              rx_stop_q <= rx_filt;
              rx_done_q <= 1'b1;
              rx_st_q   <= RX_IDLE;
            end
          end
        endcase
      end
    end
  end

  assign rx_data = rx_sh_q & serial_pkg::data_mask(lctl_q.wlen);
  assign rx_pe   = lctl_q.par_en & (rx_parbit_q != serial_pkg::par_bit(rx_data, lctl_q));

  // ----------------------------------------------------------------
  // line status; new events win over a clearing read
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rbr_q <= serial_pkg::RST_BYTE;
      dr_q  <= 1'b0;
      oe_q  <= 1'b0;
      pe_q  <= 1'b0;
      fe_q  <= 1'b0;
      bi_q  <= 1'b0;
    end else if (master_reset) begin
      dr_q <= 1'b0;
      oe_q <= 1'b0;
      pe_q <= 1'b0;
      fe_q <= 1'b0;
      bi_q <= 1'b0;
    end else begin
      if (rd && hit(widx, serial_pkg::ADDR_DATA)) dr_q <= 1'b0;
      if (rd && hit(widx, serial_pkg::ADDR_LSTA)) begin
        oe_q <= 1'b0;
        pe_q <= 1'b0;
        fe_q <= 1'b0;
        bi_q <= 1'b0;
      end
      if (rx_done_q) begin
        rbr_q <= rx_data;
        dr_q  <= 1'b1;
        if (dr_q) oe_q <= 1'b1;
        if (rx_pe) pe_q <= 1'b1;
        if (!rx_stop_q) fe_q <= 1'b1;
        if (!rx_stop_q && rx_sh_q == 8'h00 && !rx_parbit_q) bi_q <= 1'b1;
      end
    end
  end

  // empty-holding event; cleared by a data write or by reading its identity
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      thre_int_q <= 1'b0;
    end else if (master_reset) begin
      thre_int_q <= 1'b0;
    end else if (thr_load) begin
      thre_int_q <= 1'b1;
    end else if (wr && hit(widx, serial_pkg::ADDR_DATA)) begin
      thre_int_q <= 1'b0;
    end else if (rd && hit(widx, serial_pkg::ADDR_IID) && iid == serial_pkg::IID_THRE) begin
      thre_int_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // modem status
  // ----------------------------------------------------------------
  // order of levels: carrier, ring, set-ready, clear-to-send
  assign mlevel = mctl_q.loop ? {mctl_q.out2, mctl_q.out1, mctl_q.dtr, mctl_q.rts}
                              : ~{carrier_detect_in_n, ring_indicator_in_n,
                                  set_ready_in_n, clear_to_send_in_n};

  // change flags: delta carrier, ring trailing edge, delta ready, delta cts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mprev_q  <= 4'h0;
      mdelta_q <= 4'h0;
    end else begin
      mprev_q <= mlevel;
      if (rd && hit(widx, serial_pkg::ADDR_MSTA)) mdelta_q <= 4'h0;
      if (mlevel[3] != mprev_q[3]) mdelta_q[3] <= 1'b1;
      if (mprev_q[2] && !mlevel[2]) mdelta_q[2] <= 1'b1;
      if (mlevel[1] != mprev_q[1]) mdelta_q[1] <= 1'b1;
      if (mlevel[0] != mprev_q[0]) mdelta_q[0] <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // interrupt identity and request
  // ----------------------------------------------------------------
  always_comb begin
    if (ien_q[2] && (oe_q | pe_q | fe_q | bi_q)) begin
      iid = serial_pkg::IID_LINE;
    end else if (ien_q[0] && dr_q) begin
      iid = serial_pkg::IID_RXRDY;
    end else if (ien_q[1] && thre_int_q) begin
      iid = serial_pkg::IID_THRE;
    end else if (ien_q[3] && (|mdelta_q)) begin
      iid = serial_pkg::IID_MODEM;
    end else begin
      iid = serial_pkg::IID_NONE;
    end
  end

  // any of ten events funnels into one registered request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= ~iid[0];
    end
  end

  // ----------------------------------------------------------------
  // read data, captured in the setup cycle
  // ----------------------------------------------------------------
  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (1'b1)
      hit(widx, serial_pkg::ADDR_DATA): rd_val[7:0]  = rbr_q;
      hit(widx, serial_pkg::ADDR_IEN):  rd_val[7:0]  = ien_q;
      hit(widx, serial_pkg::ADDR_IID):  rd_val[7:0]  = iid;
      hit(widx, serial_pkg::ADDR_LCTL): rd_val[7:0]  = lctl_q;
      hit(widx, serial_pkg::ADDR_MCTL): rd_val[7:0]  = mctl_q;
      hit(widx, serial_pkg::ADDR_LSTA): rd_val[7:0]  = {1'b0,
          (tx_st_q == TX_IDLE) & ~thr_full_q, ~thr_full_q, bi_q, fe_q, pe_q, oe_q, dr_q};
      hit(widx, serial_pkg::ADDR_MSTA): rd_val[7:0]  = {mlevel, mdelta_q};
      hit(widx, serial_pkg::ADDR_SCR):  rd_val[7:0]  = scr_q;
      hit(widx, serial_pkg::ADDR_DIV):  rd_val[15:0] = div_q;
      default:                          rd_val       = 32'h0000_0000;
    endcase
  end

  // status is frozen at setup, so the clearing access returns what it clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_val;
    end
  end

endmodule

// ===== serial_line_ctrl_chk.sv
// port assertions for the serial line controller
`timescale 1ns/1ps
module serial_line_ctrl_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        master_reset,
  input wire logic        serial_tx_line,
  input wire logic        tx_bit_clock_out_n,
  input wire logic        request_to_send_out_n,
  input wire logic        terminal_ready_out_n,
  input wire logic        user_output_one_n,
  input wire logic        user_output_two_n,
  input wire logic        irq
);
  logic [7:0]  scr_q;
  logic [15:0] div_q;
  logic [3:0]  mc_q;
  logic [3:0]  pins;
  logic        wr;
  logic        rs;
  // access phase of a write, setup of a read
  assign wr = psel && penable && pwrite;
  assign rs = psel && !penable && !pwrite;
  assign pins = {user_output_two_n, user_output_one_n, request_to_send_out_n,
                 terminal_ready_out_n};
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn || master_reset);
  // shadows of software writes; scratch survives a master reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scr_q <= 8'h00;
      div_q <= 16'h0000;
      mc_q <= 4'h0;
    end else begin
      if (wr && paddr == serial_pkg::ADDR_SCR) scr_q <= pwdata[7:0];
      if (master_reset) div_q <= 16'h0000;
      else if (wr && paddr == serial_pkg::ADDR_DIV) div_q <= pwdata[15:0];
      if (wr && paddr == serial_pkg::ADDR_MCTL) mc_q <= pwdata[3:0];
    end
  end
  chk_slverr_range: assert property (psel && penable |-> pslverr == (paddr[11:2] > 10'h008))
    else $error("bad pslverr");
  chk_unmapped_zero: assert property (rs && paddr[11:2] > 10'h008 |=> prdata == 32'h0)
    else $error("unmapped read");
  chk_scratch_back: assert property (rs && paddr == serial_pkg::ADDR_SCR
    |=> prdata == {24'h0, scr_q})
    else $error("bad scratch");
  chk_modem_pins: assert property (wr && paddr == serial_pkg::ADDR_MCTL && !pwdata[4]
    |-> ##2 pins == ~mc_q)
    else $error("bad modem pins");
  chk_loop_quiet: assert property (wr && paddr == serial_pkg::ADDR_MCTL && pwdata[4]
    |-> ##2 serial_tx_line && pins == 4'hF)
    else $error("loop pins");
  chk_reset_outputs: assert property (disable iff (!presetn) master_reset [*2]
    |=> !irq && serial_tx_line && pins == 4'hF)
    else $error("master reset");
  chk_baud_idle: assert property ((div_q == 16'h0000) [*3] |-> tx_bit_clock_out_n)
    else $error("baud runs");
  chk_baud_pulse: assert property ($fell(tx_bit_clock_out_n) && div_q == 16'h0004
    |=> tx_bit_clock_out_n [*3] ##1 !tx_bit_clock_out_n)
    else $error("baud period");
endmodule
bind serial_line_ctrl serial_line_ctrl_chk i_serial_line_ctrl_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pslverr(pslverr), .master_reset(master_reset), .serial_tx_line(serial_tx_line),
  .tx_bit_clock_out_n(tx_bit_clock_out_n), .request_to_send_out_n(request_to_send_out_n),
  .terminal_ready_out_n(terminal_ready_out_n), .user_output_one_n(user_output_one_n),
  .user_output_two_n(user_output_two_n), .irq(irq));

// ===== serial_peer.sv
// serial line peer: sample clock, framed characters, modem levels
`timescale 1ns/1ps
module serial_peer (
  output logic       rclk,
  output logic       line,
  output logic [3:0] modem_n
);
  // idle line high, modem inputs {carrier, ring, ready, clear} released
  initial begin
    rclk = 1'b0;
    line = 1'b1;
    modem_n = 4'hF;
  end
  // sixteen samples per bit, four pclk each to suit a divisor of four
  always #50 rclk = ~rclk;
  // one bit time on the line
  task automatic put(input logic b);
    line <= b;
    repeat (16) @(posedge rclk);
  endtask
  // one-sample glitch first, then start, data lsb first, parity, stop
  task automatic send(input logic [7:0] d, input int n, input logic pe, p, stp);
    @(posedge rclk);
    line <= 1'b0;
    @(posedge rclk);
    put(1'b1);
    put(1'b0);
    for (int i = 0; i < n; i++) begin
      put(d[i]);
    end
    if (pe) begin
      put(p);
    end
    put(stp);
    put(1'b1);
    put(1'b1);
  endtask
endmodule

// ===== tb_serial_line_ctrl.sv
// self-checking bench for the serial line controller
`timescale 1ns/1ps
module tb_serial_line_ctrl;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        master_reset = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, v, s;
  logic [7:0]  d, lc;
  logic [3:0]  m, m_n;
  logic        pready, pslverr, err, p, rclk, serial_rx_line, serial_tx_line, tx_bit_clock_out_n;
  logic        request_to_send_out_n, terminal_ready_out_n, user_output_one_n, user_output_two_n;
  logic        irq;
  int          errors = 0, n_compared = 0, seed = 32'h0EE8FD6A;
  wire [3:0]   pins = {user_output_two_n, user_output_one_n, request_to_send_out_n,
                       terminal_ready_out_n};
  serial_line_ctrl i_serial_line_ctrl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .master_reset, .rclk, .serial_rx_line, .serial_tx_line,
    .tx_bit_clock_out_n, .request_to_send_out_n, .terminal_ready_out_n, .user_output_one_n,
    .user_output_two_n, .carrier_detect_in_n(m_n[3]), .ring_indicator_in_n(m_n[2]),
    .set_ready_in_n(m_n[1]), .clear_to_send_in_n(m_n[0]), .irq);
  serial_peer i_serial_peer (.rclk, .line(serial_rx_line), .modem_n(m_n));
  always #12.5 pclk = ~pclk;
  task automatic cmp(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one apb transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input string nm, input logic [31:0] e, input logic [11:0] a);
    apb(1'b0, a, 32'h0);
    cmp(nm, e, rd);
  endtask
  // new modem input levels, settle, then read status
  task automatic mset(input logic [3:0] lv);
    i_serial_peer.modem_n <= lv;
    repeat (4) @(posedge pclk);
    apb(1'b0, serial_pkg::ADDR_MSTA, 32'h0);
  endtask
  task automatic print_verdict();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // registers, modem pins, framed receive, loop-back, interrupt, master reset
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    s = 32'($random(seed)) & 32'hFF;
    apb(1'b1, serial_pkg::ADDR_SCR, s);
    rdc("scratch", s, serial_pkg::ADDR_SCR);
    rdc("unmapped", 32'h0, 12'h024);
    cmp("slverr", 32'h1, 32'(err));
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, serial_pkg::ADDR_MCTL, 32'h1 << i);
      repeat (2) @(posedge pclk);
      cmp("modem out", ~(32'h1 << i) & 32'hF, 32'(pins));
    end
    m = 4'($random(seed));
    mset(m);
    cmp("modem in", {24'h0, ~m, 4'h0}, rd & 32'hF0);
    mset(4'hB);
    cmp("ring fall", 32'h0, rd & 32'h4);
    mset(4'hF);
    cmp("ring rise", 32'h4, rd & 32'h4);
    mset(4'hF);
    cmp("deltas", 32'h0, rd & 32'hF);
    // carrier goes active with modem, line and receive interrupts enabled
    apb(1'b1, serial_pkg::ADDR_IEN, 32'hD);
    i_serial_peer.modem_n <= 4'h7;
    repeat (3) @(posedge pclk);
    cmp("modem irq", 32'h1, 32'(irq));
    rdc("modem irq id", 32'(serial_pkg::IID_MODEM), serial_pkg::ADDR_IID);
    $display("test registers done");
    apb(1'b1, serial_pkg::ADDR_DIV, 32'h4);
    for (int i = 0; i < 4; i++) begin
      lc = {2'b00, i == 3, i[0], i != 0, i[1], i[1:0]};
      d = 8'($random(seed)) & (8'hFF >> (3 - i)) | 8'h01;
      p = (i == 3) ? 1'b0 : (^d ^ !lc[4]);
      apb(1'b1, serial_pkg::ADDR_LCTL, 32'(lc));
      i_serial_peer.send(d, 5 + i, lc[3], p ^ (i == 2), i != 1);
      rdc("rx irq id", 32'(i % 3 ? serial_pkg::IID_LINE : serial_pkg::IID_RXRDY),
          serial_pkg::ADDR_IID);
      rdc("line status", {25'h0, 3'b110, i == 1, i == 2, 2'b01}, serial_pkg::ADDR_LSTA);
      rdc("rx data", 32'(d), serial_pkg::ADDR_DATA);
    end
    $display("test receive done");
    apb(1'b1, serial_pkg::ADDR_LCTL, 32'h3);
    apb(1'b1, serial_pkg::ADDR_MCTL, 32'h1F);
    v = 32'($random(seed)) & 32'hFF;
    apb(1'b1, serial_pkg::ADDR_DATA, v);
    do apb(1'b0, serial_pkg::ADDR_LSTA, 32'h0); while (rd[0] !== 1'b1);
    rdc("loop data", v, serial_pkg::ADDR_DATA);
    apb(1'b0, serial_pkg::ADDR_MSTA, 32'h0);
    cmp("loop modem", 32'hF0, rd & 32'hF0);
    apb(1'b1, serial_pkg::ADDR_IEN, 32'h2);
    repeat (2) @(posedge pclk);
    cmp("irq set", 32'h1, 32'(irq));
    rdc("irq id", 32'(serial_pkg::IID_THRE), serial_pkg::ADDR_IID);
    repeat (2) @(posedge pclk);
    cmp("irq clear", 32'h0, 32'(irq));
    master_reset <= 1'b1;
    repeat (3) @(posedge pclk);
    master_reset <= 1'b0;
    rdc("mctl reset", 32'h0, serial_pkg::ADDR_MCTL);
    rdc("scratch kept", s, serial_pkg::ADDR_SCR);
    $display("test loopback done");
    print_verdict();
  end
  // the tests need about 4000 cycles; a hang ends the run as a mismatch
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    print_verdict();
  end
endmodule
